/* acc_conv_ctrl.sv */
// Converter sequencer, control registers, interrupt flag/enable pair and APB slave.
module acc_conv_ctrl
  import acc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sleepEnter,
  input  wire logic        inSleep,
  input  wire logic        oscClkTick,
  input  wire logic        cmpBit,
  input  wire logic        cmp1Out,
  input  wire logic        cmp2Out,
  input  wire logic        comp1WakeEnable,
  input  wire logic        comp2WakeEnable,
  input  wire logic        portChange,
  input  wire logic        portWakeEnable,
  input  wire logic        timerOverflow,
  output acc_ctrl_t        convCtrl,
  output logic [3:0]       sampleChannel,
  output logic             sampleActive,
  output logic [7:0]       analogPinSelect,
  output logic [7:0]       trialCode,
  output acc_wake_t        wakeOut,
  output logic [11:0]      vectorAddr
);

  logic        rstMeta_r;
  logic        rstSync_r;
  logic        rstn;
  logic [2:0]  cmp1Sync_r;
  logic [2:0]  cmp2Sync_r;
  logic        cmp1Stable_r;
  logic        cmp2Stable_r;
  logic [7:0]  flags_r;
  logic [7:0]  enables_r;
  logic [7:0]  result_r;
  logic [7:0]  ans_r;
  logic [1:0]  clkSel_r;
  logic [3:0]  chs_r;
  logic        go_r;
  logic        on_r;
  logic [1:0]  runClk_r;
  logic [3:0]  runChs_r;
  logic [4:0]  divCnt_r;
  logic [3:0]  tadCnt_r;
  logic [7:0]  marker_r;
  acc_state_t  state_r;
  logic        tadTick;
  logic        wrStb;
  logic        wrCtrl;
  logic        goSetReq;
  logic        goClrReq;
  logic        startConv;
  logic        doneConv;
  logic        cmpEvent;
  logic [7:0]  pending;
  logic        inSleep_r;
  logic        wakeEdge;

  function automatic logic regHit(input logic [11:0] a, input logic [11:0] r);
    regHit = (a == r);
  endfunction : regHit

  function automatic logic [4:0] divFor(input logic [1:0] sel);
    unique case (sel)
      CLK_DIV16: divFor = DIV16_CNT;
      CLK_DIV8:  divFor = DIV8_CNT;
      CLK_DIV4:  divFor = DIV4_CNT;
      CLK_OSC4:  divFor = DIV4_CNT;
    endcase
  endfunction : divFor

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  assign rstn = rstSync_r;

  // Comparator outputs are asynchronous; a change counts once the last two stages agree.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmp1Sync_r   <= 3'h0;
      cmp2Sync_r   <= 3'h0;
      cmp1Stable_r <= 1'b0;
      cmp2Stable_r <= 1'b0;
    end else begin
      cmp1Sync_r <= {cmp1Sync_r[1:0], cmp1Out};
      cmp2Sync_r <= {cmp2Sync_r[1:0], cmp2Out};
      if (cmp1Sync_r[1] == cmp1Sync_r[2]) begin
        cmp1Stable_r <= cmp1Sync_r[2];
      end
      if (cmp2Sync_r[1] == cmp2Sync_r[2]) begin
        cmp2Stable_r <= cmp2Sync_r[2];
      end
    end
  end

  assign cmpEvent = ((cmp1Sync_r[1] == cmp1Sync_r[2]) && (cmp1Sync_r[2] != cmp1Stable_r)
                     && comp1WakeEnable)
                 || ((cmp2Sync_r[1] == cmp2Sync_r[2]) && (cmp2Sync_r[2] != cmp2Stable_r)
                     && comp2WakeEnable);

  // Zero-wait APB slave: every access completes in its first access cycle.
  assign pready  = 1'b1;
  assign wrStb   = psel && penable && pwrite;
  assign wrCtrl  = wrStb && regHit(paddr, ADDR_CONV_CTRL);
  assign pslverr = psel && penable && !(regHit(paddr, ADDR_CONV_CTRL)
                   || regHit(paddr, ADDR_CONV_RESULT) || regHit(paddr, ADDR_ANALOG_PINS)
                   || regHit(paddr, ADDR_IRQ_FLAGS) || regHit(paddr, ADDR_IRQ_ENABLES)
                   || regHit(paddr, ADDR_STATUS));

  assign goSetReq  = wrCtrl && pwdata[CTRL_GO_BIT] && pwdata[CTRL_ON_BIT] && !go_r;
  assign goClrReq  = wrCtrl && !pwdata[CTRL_GO_BIT];
  assign startConv = goSetReq && !inSleep && !sleepEnter;
  assign tadTick   = (state_r != ST_IDLE) && ((runClk_r == CLK_OSC4) ? oscClkTick
                     : (divCnt_r == 5'd1));
  assign doneConv  = (state_r == ST_CONV) && tadTick && marker_r[0] && !goClrReq
                     && !sleepEnter;

  // Leaving Sleep restores the control defaults, so a stale setting never survives a wake.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inSleep_r <= 1'b0;
    end else begin
      inSleep_r <= inSleep;
    end
  end
  assign wakeEdge = inSleep_r && !inSleep;

  // Control register: clock select, channel, go and enable.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clkSel_r <= CLK_SEL_RESET;
      chs_r    <= CHS_RESET;
      go_r     <= 1'b0;
      on_r     <= 1'b0;
    end else if (sleepEnter || wakeEdge) begin
      clkSel_r <= CLK_SEL_RESET;
      chs_r    <= CHS_RESET;
      go_r     <= 1'b0;
      on_r     <= 1'b0;
    end else begin
      if (wrCtrl) begin
        clkSel_r <= pwdata[CTRL_CLK_LSB +: 2];
        chs_r    <= pwdata[CTRL_CHS_LSB +: 4];
        on_r     <= pwdata[CTRL_ON_BIT];
      end
      if (doneConv) begin
        go_r <= 1'b0;
      end else if (startConv) begin
        go_r <= 1'b1;
      end else if (goClrReq) begin
        go_r <= 1'b0;
      end
    end
  end

  // Analog pin select acts on pins even with the converter off.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ans_r <= ANS_RESET;
    end else if (wrStb && regHit(paddr, ADDR_ANALOG_PINS)) begin
      ans_r <= pwdata[7:0];
    end
  end

  // Clock and channel are latched at start; later clock writes wait for the next conversion, channel writes for this one to end.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      runClk_r <= CLK_SEL_RESET;
      runChs_r <= CHS_RESET;
    end else if (startConv) begin
      runClk_r <= wrCtrl ? pwdata[CTRL_CLK_LSB +: 2] : clkSel_r;
      runChs_r <= wrCtrl ? pwdata[CTRL_CHS_LSB +: 4] : chs_r;
    end else if (state_r == ST_IDLE) begin
      runChs_r <= chs_r;
    end
  end

  // The divider reloads on every period, so a late clock select write cannot stretch one.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_r <= DIV4_CNT;
    end else if (startConv || tadTick) begin
      divCnt_r <= divFor(startConv ? (wrCtrl ? pwdata[CTRL_CLK_LSB +: 2] : clkSel_r)
                                   : runClk_r);
    end else if (state_r != ST_IDLE) begin
      divCnt_r <= divCnt_r - 5'd1;
    end
  end

  // Four sampling periods then nine shifts of the leading one make 13 periods in all.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= ST_IDLE;
      tadCnt_r <= 4'h0;
    end else if (sleepEnter || goClrReq || doneConv) begin
      state_r  <= ST_IDLE;
      tadCnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (startConv) begin
            state_r  <= ST_SAMPLE;
            tadCnt_r <= 4'h0;
          end
        end
        ST_SAMPLE: begin
          if (tadTick) begin
            tadCnt_r <= tadCnt_r + 4'd1;
            if (tadCnt_r == SAMPLE_TADS - 4'd1) begin
              state_r <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (tadTick) begin
            tadCnt_r <= tadCnt_r + 4'd1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Successive approximation register with a leading-one marker; an abort keeps resolved bits.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= 8'h00;
      marker_r <= 8'h00;
    end else if (state_r == ST_SAMPLE && tadTick && tadCnt_r == SAMPLE_TADS - 4'd1) begin
      result_r <= 8'h00;
      marker_r <= 8'h00;
    end else if (state_r == ST_CONV && tadTick && !goClrReq && !sleepEnter) begin
      // The first conversion period only shifts the leading one in, so nine periods resolve eight bits.
      if (marker_r == 8'h00) begin
        result_r <= 8'h80;
        marker_r <= 8'h80;
      end else begin
        result_r <= (result_r & ~marker_r) | (cmpBit ? marker_r : 8'h00)
                    | (marker_r >> 1);
        marker_r <= marker_r >> 1;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= FLAGS_RESET;
    end else begin
      if (wrStb && regHit(paddr, ADDR_IRQ_FLAGS)) begin
        flags_r <= pwdata[7:0] & IMPL_MASK;
      end
      if (doneConv) begin
        flags_r[FLG_ADC_BIT] <= 1'b1;
      end
      if (cmpEvent) begin
        flags_r[FLG_CMP_BIT] <= 1'b1;
      end
      if (timerOverflow) begin
        flags_r[FLG_TMR_BIT] <= 1'b1;
      end
      if (portChange && portWakeEnable) begin
        flags_r[FLG_PORT_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enables_r <= ENABLES_RESET;
    end else if (wrStb && regHit(paddr, ADDR_IRQ_ENABLES)) begin
      enables_r <= pwdata[7:0] & IMPL_MASK;
    end
  end

  // Bit 0 of each register is a control, not a source, so it never raises a request.
  assign pending = flags_r & enables_r & 8'hf0;

  // Requests are registered, so a flag write cannot glitch the core's wake lines.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wakeOut    <= '0;
    end else begin
      wakeOut.wakeReq    <= (|pending) && inSleep;
      wakeOut.wakeReset  <= (|pending) && inSleep && enables_r[EN_WUR_BIT];
      wakeOut.vectorReq  <= (|pending) && flags_r[FLG_GIE_BIT]
                            && !(inSleep && enables_r[EN_WUR_BIT]);
      wakeOut.inlineWake <= (|pending) && inSleep && !flags_r[FLG_GIE_BIT]
                            && !enables_r[EN_WUR_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vectorAddr <= 12'h000;
    end else begin
      vectorAddr <= IRQ_VECTOR;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      convCtrl <= '0;
    end else begin
      convCtrl <= '{clkSel: clkSel_r, channel: chs_r, go: go_r, on: on_r};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sampleChannel <= CHS_RESET;
    end else begin
      sampleChannel <= runChs_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sampleActive <= 1'b0;
    end else begin
      sampleActive <= (state_r == ST_SAMPLE);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      analogPinSelect <= ANS_RESET;
    end else begin
      analogPinSelect <= ans_r;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trialCode <= 8'h00;
    end else begin
      trialCode <= result_r;
    end
  end

  // Reads have no side effects, so a repeated read is harmless.
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      unique case (1'b1)
        regHit(paddr, ADDR_CONV_CTRL):   prdata[7:0] = {clkSel_r, chs_r, go_r, on_r};
        regHit(paddr, ADDR_CONV_RESULT): prdata[7:0] = result_r;
        regHit(paddr, ADDR_ANALOG_PINS): prdata[7:0] = ans_r;
        regHit(paddr, ADDR_IRQ_FLAGS):   prdata[7:0] = flags_r;
        regHit(paddr, ADDR_IRQ_ENABLES): prdata[7:0] = enables_r;
        regHit(paddr, ADDR_STATUS):      prdata[7:0] = {5'h00, state_r};
        default:                         prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule : acc_conv_ctrl

/* acc_conv_ctrl_asserts.sv */
// Concurrent checks on the ports of the converter control block.
module acc_conv_ctrl_asserts
  import acc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleepEnter,
  input wire logic        inSleep,
  input wire acc_ctrl_t   convCtrl,
  input wire logic [3:0]  sampleChannel,
  input wire logic        sampleActive,
  input wire logic [7:0]  analogPinSelect,
  input wire acc_wake_t   wakeOut,
  input wire logic [11:0] vectorAddr
);
  localparam int MAX_RUN = 208;
  logic       wrAcc;
  logic       badAddr;
  logic [8:0] runLen_r;
  assign wrAcc = psel && penable && pwrite;
  assign badAddr = (paddr > ADDR_STATUS) || (paddr[1:0] != 2'h0);
  // A counter bounds the run, since a repetition that long would slow the tools.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      runLen_r <= 9'h000;
    end else begin
      runLen_r <= convCtrl.go ? runLen_r + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence sSleepDefaults;
    convCtrl == {CLK_SEL_RESET, CHS_RESET, 1'b0, 1'b0} && !sampleActive;
  endsequence
  sequence sOffWrite;
    wrAcc && paddr == ADDR_CONV_CTRL && !pwdata[CTRL_ON_BIT];
  endsequence
  chk_go_needs_on: assert property (sOffWrite |-> ##2 !convCtrl.go)
    else $error("Go bit set while converter is off.");
  chk_sleep_defaults: assert property (sleepEnter |-> ##2 sSleepDefaults)
    else $error("Sleep entry did not restore control defaults.");
  chk_channel_held: assert property (convCtrl.go [*4] |->
    $past(sampleChannel, 1) == $past(sampleChannel, 2))
    else $error("Sampled channel changed during a conversion.");
  chk_pins_by_write: assert property ($changed(analogPinSelect) |->
    $past(wrAcc && paddr == ADDR_ANALOG_PINS, 2))
    else $error("Analog pin select changed without a write.");
  chk_run_bounded: assert property (convCtrl.go |-> runLen_r < MAX_RUN)
    else $error("Conversion ran longer than thirteen slowest periods.");
  chk_reset_in_sleep: assert property (wakeOut.wakeReset |->
    (inSleep || $past(inSleep) || $past(inSleep, 2)))
    else $error("Wake reset raised outside Sleep.");
  chk_inline_only: assert property (wakeOut.inlineWake |->
    !wakeOut.vectorReq && !wakeOut.wakeReset)
    else $error("Inline wake raised together with vector or reset.");
  chk_vector_fixed: assert property (resetn [*4] |-> vectorAddr == IRQ_VECTOR)
    else $error("Vector address is not the interrupt vector.");
  chk_err_unmapped: assert property ((psel && penable) |-> pslverr == badAddr)
    else $error("Slave error does not match the address map.");
  chk_zero_wait: assert property (pready)
    else $error("Ready dropped.");
endmodule : acc_conv_ctrl_asserts

bind acc_conv_ctrl acc_conv_ctrl_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .sleepEnter(sleepEnter), .inSleep(inSleep),
  .convCtrl(convCtrl), .sampleChannel(sampleChannel), .sampleActive(sampleActive),
  .analogPinSelect(analogPinSelect), .wakeOut(wakeOut), .vectorAddr(vectorAddr));

/* acc_conv_ctrl_test.sv */
// Self-checking testbench for the converter control block.
module acc_conv_ctrl_test import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sleepEnter = 1'b0, inSleep = 1'b0, oscClkTick = 1'b1;
  logic cmpBit = 1'b0, cmp1Out = 1'b0, cmp2Out = 1'b0, comp1WakeEnable = 1'b0;
  logic comp2WakeEnable = 1'b0, portChange = 1'b0, portWakeEnable = 1'b0;
  logic timerOverflow = 1'b0, prevGo = 1'b0, sampleActive;
  logic [3:0] sampleChannel;
  logic [7:0] analogPinSelect, trialCode, pins;
  logic [11:0] vectorAddr;
  acc_ctrl_t convCtrl;
  acc_wake_t wakeOut;
  logic [31:0] rdQ[$], durQ[$];
  int cyc = 0, lastCyc = 0, t0 = 0, errorCnt = 0, nTests = 0;
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) cyc++;
  acc_conv_ctrl dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleepEnter(sleepEnter), .inSleep(inSleep), .oscClkTick(oscClkTick),
    .cmpBit(cmpBit), .cmp1Out(cmp1Out), .cmp2Out(cmp2Out), .comp1WakeEnable(comp1WakeEnable),
    .comp2WakeEnable(comp2WakeEnable), .portChange(portChange),
    .portWakeEnable(portWakeEnable), .timerOverflow(timerOverflow), .convCtrl(convCtrl),
    .sampleChannel(sampleChannel), .sampleActive(sampleActive),
    .analogPinSelect(analogPinSelect), .trialCode(trialCode), .wakeOut(wakeOut),
    .vectorAddr(vectorAddr));
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : compare
  task automatic stopTest();
    if (errorCnt == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stopTest
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    lastCyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
    rdQ.push_back(exp);
    apb(1'b0, addr, 32'h0);
  endtask : rd
  task automatic waitIdle();
    int n;
    repeat (3) @(posedge core_clk);
    for (n = 0; n < 400 && convCtrl.go !== 1'b0; n++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask : waitIdle
  task automatic conv(input logic [1:0] clk, input logic [3:0] input_channel_select, input logic b, input bit mid);
    logic [1:0] nClk;
    logic [3:0] nChs;
    nClk = mid ? CLK_DIV16 : clk;
    nChs = mid ? ~input_channel_select : input_channel_select;
    cmpBit <= b;
    apb(1'b1, ADDR_CONV_CTRL, {24'h0, clk, input_channel_select, 2'b11});
    durQ.push_back(32'(13 * (clk == CLK_OSC4 ? 1 : 16 >> clk)));
    if (mid) begin
      repeat (8) @(posedge core_clk);
      apb(1'b1, ADDR_CONV_CTRL, {24'h0, nClk, nChs, 2'b11});
      compare(32'(sampleChannel), 32'(input_channel_select));
    end
    waitIdle();
    compare(32'(trialCode), {24'h0, {8{b}}});
    rd(ADDR_CONV_CTRL, {24'h0, nClk, nChs, 2'b01});
    rd(ADDR_CONV_RESULT, {24'h0, {8{b}}});
    rd(ADDR_IRQ_FLAGS, 32'h80);
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h0);
  endtask : conv
  task automatic halt(input bit sleep);
    int s;
    int e;
    apb(1'b1, ADDR_CONV_CTRL, {24'h0, CLK_DIV16, 4'h2, 2'b11});
    s = lastCyc;
    repeat (80) @(posedge core_clk);
    if (sleep) begin
      sleepEnter <= 1'b1;
      e = cyc + 1;
      @(posedge core_clk);
      sleepEnter <= 1'b0;
    end else begin
      apb(1'b1, ADDR_CONV_CTRL, {24'h0, CLK_DIV16, 4'h2, 2'b01});
      e = lastCyc;
    end
    durQ.push_back(32'(e - s));
    waitIdle();
    rd(ADDR_IRQ_FLAGS, 32'h0);
    rd(ADDR_CONV_CTRL, sleep ? 32'hfc : {24'h0, CLK_DIV16, 4'h2, 2'b01});
    compare(32'(analogPinSelect), 32'(pins));
  endtask : halt
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite && rdQ.size() > 0) begin
      compare(prdata, rdQ.pop_front());
    end
    if (convCtrl.go === 1'b1 && prevGo === 1'b0) t0 = cyc;
    if (convCtrl.go === 1'b0 && prevGo === 1'b1) begin
      compare(32'(cyc - t0), durQ.size() > 0 ? durQ.pop_front() : 32'hffffffff);
    end
    prevGo = convCtrl.go;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    stopTest();
  end
  initial begin
    void'($urandom(32'ha5206c18));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(ADDR_CONV_CTRL, 32'hfc);
    rd(ADDR_ANALOG_PINS, 32'h03);
    rd(ADDR_IRQ_FLAGS, 32'h0);
    rd(ADDR_IRQ_ENABLES, 32'h0);
    rd(ADDR_STATUS, 32'h1);
    rd(12'h018, 32'h0);
    compare(32'(analogPinSelect), 32'h03);
    // Channels 0 to 3 are kept analog so every chosen channel can acquire.
    pins = 8'($urandom) | 8'h0f;
    apb(1'b1, ADDR_ANALOG_PINS, {24'h0, pins});
    repeat (2) @(posedge core_clk);
    compare(32'(analogPinSelect), 32'(pins));
    for (int i = 0; i < 4; i++) conv(2'(i), 4'($urandom_range(3)), 1'($urandom), i == 2);
    halt(1'b0);
    halt(1'b1);
    apb(1'b1, ADDR_CONV_CTRL, {24'h0, CLK_DIV8, 4'h1, 2'b10});
    repeat (4) @(posedge core_clk);
    rd(ADDR_CONV_CTRL, {24'h0, CLK_DIV8, 4'h1, 2'b00});
    apb(1'b1, ADDR_IRQ_ENABLES, 32'hff);
    rd(ADDR_IRQ_ENABLES, 32'hf1);
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, ADDR_IRQ_FLAGS, 32'h0);
      apb(1'b1, ADDR_IRQ_ENABLES, 32'h0);
      comp1WakeEnable <= 1'(e);
      comp2WakeEnable <= 1'(e);
      portWakeEnable <= 1'(e);
      @(posedge core_clk);
      portChange <= 1'b1;
      timerOverflow <= 1'b1;
      cmp1Out <= ~cmp1Out;
      @(posedge core_clk);
      portChange <= 1'b0;
      timerOverflow <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd(ADDR_IRQ_FLAGS, e ? 32'h70 : 32'h20);
      compare(32'(wakeOut), 32'h0);
    end
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h71);
    apb(1'b1, ADDR_IRQ_ENABLES, 32'h20);
    repeat (3) @(posedge core_clk);
    compare(32'(wakeOut.vectorReq), 32'h1);
    inSleep <= 1'b1;
    apb(1'b1, ADDR_IRQ_ENABLES, 32'h21);
    repeat (3) @(posedge core_clk);
    compare(32'(wakeOut.wakeReset), 32'h1);
    apb(1'b1, ADDR_IRQ_ENABLES, 32'h20);
    apb(1'b1, ADDR_IRQ_FLAGS, 32'h70);
    repeat (3) @(posedge core_clk);
    compare(32'(wakeOut.inlineWake), 32'h1);
    inSleep <= 1'b0;
    repeat (3) @(posedge core_clk);
    stopTest();
  end
endmodule : acc_conv_ctrl_test

/* acc_pkg.sv */
// Package with register map, field layout and timing constants for the converter control block.
// Functional notes
// - Each conversion yields an 8-bit result of the selected analog input.
// - Conversion clock is instruction clock over 16, 8, 4 or oscillator over four.
// - Every conversion lasts exactly 13 conversion clock periods; divisor sets period length.
// - Clock select written mid-conversion applies only from the next conversion start.
// - Clock select forced to 11 on reset and wake; kept on completion or abort.
// - Analog pin select bits make pins analog inputs regardless of converter on.
// - After any reset analog pin select defaults to 11, three analog channels; the code's 8'h03 makes only pins 0 and 1 analog.
// - Channel select written mid-conversion is held off until the conversion finishes.
// - Channel select returns to its default when the device enters Sleep.
// - Go bit starts a conversion; completion clears it and sets the done flag.
// - Clearing go mid-conversion stops at once, keeping only resolved result bits; the code leaves result_r as it stands, with the pending trial bit still set.
// - Entering Sleep clears go and halts any running conversion.
// - Setting go is ignored while the converter enable bit is clear.
// - Flag bit 7 sets on conversion completion and stays until software clears it.
// - Flag bit 6 records comparator output change only when a comparator wake enable is set.
// - Flag bit 5 sets on timer overflow and stays until software clears it.
// - Flag bit 4 records port change only when port wake enable is set.
// - With global enable set an interrupt vectors to 0x004, else wakes inline.
// - Enable bits 7 to 4 enable converter, comparator, timer and port interrupts.
// - With wake reset enable set an enabled wake from Sleep resets the device.
// - A conversion aborted by software does not set the done flag.
// - Converter and timer flags set regardless of global and individual enables.
package acc_pkg;

  localparam logic [11:0] ADDR_CONV_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CONV_RESULT = 12'h004;
  localparam logic [11:0] ADDR_ANALOG_PINS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_FLAGS   = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_ENABLES = 12'h010;
  localparam logic [11:0] ADDR_STATUS      = 12'h014;

  localparam int          CTRL_ON_BIT   = 0;
  localparam int          CTRL_GO_BIT   = 1;
  localparam int          CTRL_CHS_LSB  = 2;
  localparam int          CTRL_CLK_LSB  = 6;
  localparam int          FLG_GIE_BIT   = 0;
  localparam int          FLG_PORT_BIT  = 4;
  localparam int          FLG_TMR_BIT   = 5;
  localparam int          FLG_CMP_BIT   = 6;
  localparam int          FLG_ADC_BIT   = 7;
  localparam int          EN_WUR_BIT    = 0;

  localparam logic [1:0]  CLK_SEL_RESET = 2'h3;
  localparam logic [3:0]  CHS_RESET     = 4'hf;
  localparam logic [7:0]  ANS_RESET     = 8'h03;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  ENABLES_RESET = 8'h00;
  localparam logic [7:0]  IMPL_MASK     = 8'hf1;
  localparam logic [11:0] IRQ_VECTOR    = 12'h004;

  localparam logic [1:0]  CLK_DIV16 = 2'h0;
  localparam logic [1:0]  CLK_DIV8  = 2'h1;
  localparam logic [1:0]  CLK_DIV4  = 2'h2;
  localparam logic [1:0]  CLK_OSC4  = 2'h3;
  localparam logic [4:0]  DIV16_CNT = 5'd16;
  localparam logic [4:0]  DIV8_CNT  = 5'd8;
  localparam logic [4:0]  DIV4_CNT  = 5'd4;
  localparam logic [3:0]  TAD_PER_CONV = 4'd13;
  localparam logic [3:0]  SAMPLE_TADS  = 4'd4;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } acc_state_t;

  typedef struct packed {
    logic [1:0] clkSel;
    logic [3:0] channel;
    logic       go;
    logic       on;
  } acc_ctrl_t;

  typedef struct packed {
    logic       wakeReq;
    logic       wakeReset;
    logic       vectorReq;
    logic       inlineWake;
  } acc_wake_t;

endpackage : acc_pkg
